//--- core/audio_clock_pkg.sv
// Shared constants and types for the field-locked audio clock generator
package audio_clock_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CPF_W = 18;
    localparam int INC_W = 22;
    localparam int ACC_W = 23;
    localparam int DIV_W = 6;
    localparam int TRIM_W = 16;
    localparam int ERR_W = 19;
    localparam logic [ERR_W-1:0] ERR_CLAMP = 19'h001FF;

    localparam logic [ADDR_W-1:0] OFS_CPF_LOW = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_CPF_MID = 8'h31;
    localparam logic [ADDR_W-1:0] OFS_CPF_HIGH = 8'h32;
    localparam logic [ADDR_W-1:0] OFS_INC_LOW = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_INC_MID = 8'h35;
    localparam logic [ADDR_W-1:0] OFS_INC_HIGH = 8'h36;
    localparam logic [ADDR_W-1:0] OFS_SERIAL_CLOCK_DIVIDER = 8'h38;
    localparam logic [ADDR_W-1:0] OFS_CHANNEL_CLOCK_DIVIDER = 8'h39;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h3A;

    localparam int BIT_LOOP_OPEN = 3;
    localparam int BIT_VREF_SEL = 2;
    localparam int BIT_CH_PHASE = 1;
    localparam int BIT_SER_PHASE = 0;

    localparam logic [CPF_W-1:0] RST_CPF = 18'h00000;
    localparam logic [INC_W-1:0] RST_INC = 22'h000000;
    localparam logic [DIV_W-1:0] RST_SERIAL_CLOCK_DIVIDER = 6'h00;
    localparam logic [DIV_W-1:0] RST_CHANNEL_CLOCK_DIVIDER = 6'h00;
    localparam logic [TRIM_W-1:0] RST_TRIM = 16'h0000;

    typedef struct packed {
        logic loop_open;
        logic vertical_ref_select;
        logic channel_clock_phase;
        logic serial_clock_phase;
    } ctrl_t;

    localparam ctrl_t RST_CTRL = 4'h0;

    typedef struct packed {
        logic rise;
        logic fall;
    } edges_t;
endpackage : audio_clock_pkg

//--- core/pin_edge_sync.sv
// Two-stage synchroniser with edge detection for a pin input
`timescale 1ns/1ps
module pin_edge_sync
    import audio_clock_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output edges_t edges
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign edges.rise = sync_r & ~last_r;
    assign edges.fall = ~sync_r & last_r;
endmodule : pin_edge_sync

//--- core/field_locked_audio_clock_gen.sv
// Field-locked audio master clock synthesiser and bit/channel clock dividers
`timescale 1ns/1ps
// What this block does
// - Lock master clocks per field to count
// - Nominal 22-bit phase step per crystal cycle
// - Master clock derived from crystal clock
// - Bit clock = master in over 2(div+1)
// - Channel clock = bit clock over 2*div
// - Loop closed when clear, open when set
// - Vertical reference internal or external select
// - Channel clock follows chosen bit clock edge
// - Bit clock follows chosen master input edge
// - Same sample count delivered every field
module field_locked_audio_clock_gen
    import audio_clock_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic internal_vsync,
    input wire logic external_vsync,
    input wire logic audio_master_clock_in,
    output logic audio_master_clock_out,
    output logic audio_bit_clock,
    output logic audio_channel_clock
);
    logic [CPF_W-1:0] clocks_per_field_r;
    logic [INC_W-1:0] nominal_increment_r;
    logic [DIV_W-1:0] serial_clock_divider_r;
    logic [DIV_W-1:0] channel_clock_divider_r;
    ctrl_t ctrl_r;
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] step;
    logic [TRIM_W-1:0] trim_r;
    logic [CPF_W-1:0] count_r;
    logic [ERR_W-1:0] err;
    logic [ERR_W-1:0] err_lim;
    logic ivs_last_r;
    logic field_pulse;
    logic master_edge;
    logic bit_edge;
    logic [DIV_W-1:0] serial_clock_divider_cnt_r;
    logic [DIV_W-1:0] channel_clock_divider_cnt_r;
    logic bit_toggle;
    edges_t min_edges;
    edges_t vext_edges;

    pin_edge_sync u_min_sync (
        .clk(clk),
        .rst(rst),
        .pin(audio_master_clock_in),
        .edges(min_edges)
    );

    pin_edge_sync u_vext_sync (
        .clk(clk),
        .rst(rst),
        .pin(external_vsync),
        .edges(vext_edges)
    );

    // Subaddressed register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clocks_per_field_r <= RST_CPF;
            nominal_increment_r <= RST_INC;
            serial_clock_divider_r <= RST_SERIAL_CLOCK_DIVIDER;
            channel_clock_divider_r <= RST_CHANNEL_CLOCK_DIVIDER;
            ctrl_r <= RST_CTRL;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_CPF_LOW: clocks_per_field_r[7:0] <= reg_wdata;
                OFS_CPF_MID: clocks_per_field_r[15:8] <= reg_wdata;
                OFS_CPF_HIGH: clocks_per_field_r[17:16] <= reg_wdata[1:0];
                OFS_INC_LOW: nominal_increment_r[7:0] <= reg_wdata;
                OFS_INC_MID: nominal_increment_r[15:8] <= reg_wdata;
                OFS_INC_HIGH: nominal_increment_r[21:16] <= reg_wdata[5:0];
                OFS_SERIAL_CLOCK_DIVIDER: serial_clock_divider_r <= reg_wdata[DIV_W-1:0];
                OFS_CHANNEL_CLOCK_DIVIDER: channel_clock_divider_r <= reg_wdata[DIV_W-1:0];
                OFS_CTRL: ctrl_r <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // Registered read-back, unmapped reads as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                OFS_CPF_LOW: reg_rdata <= clocks_per_field_r[7:0];
                OFS_CPF_MID: reg_rdata <= clocks_per_field_r[15:8];
                OFS_CPF_HIGH: reg_rdata <= {6'h00, clocks_per_field_r[17:16]};
                OFS_INC_LOW: reg_rdata <= nominal_increment_r[7:0];
                OFS_INC_MID: reg_rdata <= nominal_increment_r[15:8];
                OFS_INC_HIGH: reg_rdata <= {2'h0, nominal_increment_r[21:16]};
                OFS_SERIAL_CLOCK_DIVIDER: reg_rdata <= {2'h0, serial_clock_divider_r};
                OFS_CHANNEL_CLOCK_DIVIDER: reg_rdata <= {2'h0, channel_clock_divider_r};
                OFS_CTRL: reg_rdata <= {4'h0, ctrl_r};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Field reference pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ivs_last_r <= 1'b0;
        end else begin
            ivs_last_r <= internal_vsync;
        end
    end
    assign field_pulse = ctrl_r.vertical_ref_select ? vext_edges.rise
                                                    : (internal_vsync & ~ivs_last_r);

    // Phase accumulator on the crystal clock
    assign step = ACC_W'({1'b0, nominal_increment_r} + {{(ACC_W-TRIM_W){trim_r[TRIM_W-1]}}, trim_r});
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= '0;
            audio_master_clock_out <= 1'b0;
        end else begin
            acc_r <= acc_r + step;
            audio_master_clock_out <= acc_r[ACC_W-1];
        end
    end

    // Count master clocks in each field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
        end else if (field_pulse) begin
            count_r <= '0;
        end else if (acc_r[ACC_W-1] & ~audio_master_clock_out) begin
            count_r <= count_r + 18'h00001;
        end
    end

    // Field error, clamped to keep the loop slow
    assign err = {1'b0, clocks_per_field_r} - {1'b0, count_r};
    always_comb begin
        err_lim = err;
        if (!err[ERR_W-1] && err > ERR_CLAMP) begin
            err_lim = ERR_CLAMP;
        end else if (err[ERR_W-1] && err < (~ERR_CLAMP + 19'h00001)) begin
            err_lim = ~ERR_CLAMP + 19'h00001;
        end
    end

    // Integrating trim, held at zero with loop open
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trim_r <= RST_TRIM;
        end else if (ctrl_r.loop_open) begin
            trim_r <= RST_TRIM;
        end else if (field_pulse) begin
            trim_r <= trim_r + TRIM_W'(err_lim);
        end
    end

    // Bit clock divider on returned master clock
    assign master_edge = ctrl_r.serial_clock_phase ? min_edges.rise : min_edges.fall;
    // Compare with >= so a smaller divider written mid-count takes effect at once
    assign bit_toggle = master_edge && (serial_clock_divider_cnt_r >= serial_clock_divider_r);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_clock_divider_cnt_r <= '0;
            audio_bit_clock <= 1'b0;
        end else if (master_edge) begin
            if (bit_toggle) begin
                serial_clock_divider_cnt_r <= '0;
                audio_bit_clock <= ~audio_bit_clock;
            end else begin
                serial_clock_divider_cnt_r <= serial_clock_divider_cnt_r + 6'h01;
            end
        end
    end

    // Channel clock divider on chosen bit clock edge
    assign bit_edge = bit_toggle && (ctrl_r.channel_clock_phase ? ~audio_bit_clock
                                                                : audio_bit_clock);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_clock_divider_cnt_r <= '0;
            audio_channel_clock <= 1'b0;
        end else if (bit_edge && channel_clock_divider_r != 6'h00) begin
            if (channel_clock_divider_cnt_r + 6'h01 >= channel_clock_divider_r) begin
                channel_clock_divider_cnt_r <= '0;
                audio_channel_clock <= ~audio_channel_clock;
            end else begin
                channel_clock_divider_cnt_r <= channel_clock_divider_cnt_r + 6'h01;
            end
        end
    end

    sequence field_seen_s;
        field_pulse && !ctrl_r.loop_open;
    endsequence

    acc_step_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> acc_r == $past(acc_r) + $past(step))
        else $error("accumulator did not advance by step");
    open_trim_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_r.loop_open |=> trim_r == RST_TRIM && step == ACC_W'(nominal_increment_r))
        else $error("open loop step not nominal");
    loop_trim_a: assert property (@(posedge clk) disable iff (rst)
        field_seen_s |=> trim_r == $past(trim_r) + TRIM_W'($past(err_lim)))
        else $error("closed loop trim not updated");
    field_count_a: assert property (@(posedge clk) disable iff (rst)
        field_pulse |=> count_r == 18'h00000)
        else $error("field count not restarted");
    vref_sel_a: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r.vertical_ref_select && vext_edges.rise) |-> field_pulse)
        else $error("external vertical reference ignored");
    bit_phase_a: assert property (@(posedge clk) disable iff (rst)
        $changed(audio_bit_clock) |-> $past(ctrl_r.serial_clock_phase ? min_edges.rise
                                                                      : min_edges.fall))
        else $error("bit clock moved on wrong master edge");
    bit_div_a: assert property (@(posedge clk) disable iff (rst)
        (master_edge && serial_clock_divider_cnt_r == serial_clock_divider_r) |=> $changed(audio_bit_clock))
        else $error("bit clock divider missed toggle");
    chan_phase_a: assert property (@(posedge clk) disable iff (rst)
        $changed(audio_channel_clock) |-> $past(bit_edge))
        else $error("channel clock moved on wrong bit edge");
    chan_div_a: assert property (@(posedge clk) disable iff (rst)
        $changed(audio_channel_clock) |=> channel_clock_divider_cnt_r == 6'h00)
        else $error("channel divider count not cleared");
    master_out_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> audio_master_clock_out == $past(acc_r[ACC_W-1]))
        else $error("master clock output not from accumulator");
endmodule : field_locked_audio_clock_gen

//--- sim/audio_rx_model.sv
// Far-side model: returns the master clock or makes its own slow one
`timescale 1ns/1ps
module audio_rx_model (
    input wire logic clk,
    input wire logic loopback,
    input wire logic master_out,
    output logic master_in
);
    logic [2:0] cnt_r;
    logic own_r;
    initial begin
        cnt_r = 3'h0;
        own_r = 1'b0;
    end
    // Own clock: 16 crystal cycles per period
    always @(posedge clk) begin
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
            own_r <= ~own_r;
        end
    end
    assign master_in = loopback ? master_out : own_r;
endmodule : audio_rx_model

//--- sim/field_locked_audio_clock_gen_tb.sv
// Self-checking bench for the field-locked audio clock generator
`timescale 1ns/1ps
module field_locked_audio_clock_gen_tb;
    import audio_clock_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rv;
    logic internal_vsync = 1'b0;
    logic external_vsync = 1'b0;
    logic loopback = 1'b1;
    logic mclk_in, mclk_out, bclk, chclk, m_q, b_q, c_q;
    logic watch = 1'b0;
    ctrl_t ctrl = 4'h0;
    int err_count = 0;
    int compares = 0;
    int n_m, n_b, n_c;
    logic [7:0] offs [10] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3A, 8'h33};
    logic [7:0] masks [10] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h0F, 8'h00};

    always #12.5 clk = ~clk;

    field_locked_audio_clock_gen field_locked_audio_clock_gen_i (.clk(clk), .rst(rst),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .internal_vsync(internal_vsync), .external_vsync(external_vsync),
        .audio_master_clock_in(mclk_in), .audio_master_clock_out(mclk_out),
        .audio_bit_clock(bclk), .audio_channel_clock(chclk));
    audio_rx_model audio_rx_model_i (.clk(clk), .loopback(loopback), .master_out(mclk_out),
        .master_in(mclk_in));

    task automatic fail(input string msg);
        err_count++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask : fail
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) fail("register value");
    endtask : check_byte
    task automatic check_count(input int got, input int exp, input int tol);
        compares++;
        if (got < exp - tol || got > exp + tol) fail("edge count");
    endtask : check_count
    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) fail("edge phase");
    endtask : check_bit

    // Edge counters and phase watch over a measuring window
    always @(posedge clk) begin
        m_q <= mclk_out;
        b_q <= bclk;
        c_q <= chclk;
        if (watch) begin
            if (mclk_out & ~m_q) n_m++;
            if (bclk != b_q) begin
                n_b++;
                if (!loopback) check_bit(mclk_in, ctrl.serial_clock_phase);
            end
            if (chclk != c_q) begin
                n_c++;
                if (!loopback) check_bit(bclk, ctrl.channel_clock_phase);
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 d = reg_rdata;
    endtask : rd
    task automatic measure(input int w);
        n_m = 0;
        n_b = 0;
        n_c = 0;
        @(posedge clk);
        watch <= 1'b1;
        repeat (w) @(posedge clk);
        watch <= 1'b0;
        // Let the last counted edge settle before the counts are read
        @(posedge clk);
    endtask : measure
    // Fields of 200 cycles on the internal or the external reference
    task automatic fields(input int n, input logic ext);
        repeat (n) begin
            @(posedge clk);
            if (ext) external_vsync <= 1'b1;
            else internal_vsync <= 1'b1;
            repeat (4) @(posedge clk);
            internal_vsync <= 1'b0;
            external_vsync <= 1'b0;
            repeat (195) @(posedge clk);
        end
    endtask : fields
    task automatic tally_and_finish;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(offs[i], rv);
            check_byte(rv, 8'h00);
        end
        for (int i = 0; i < 10; i++) wr(offs[i], 8'hFF);
        for (int i = 0; i < 10; i++) begin
            rd(offs[i], rv);
            check_byte(rv, masks[i]);
        end
        // Step 0x100000 gives a master period of 8 cycles
        wr(OFS_INC_LOW, 8'h00);
        wr(OFS_INC_MID, 8'h00);
        wr(OFS_INC_HIGH, 8'h10);
        wr(OFS_CTRL, 8'h08);
        repeat (20) @(posedge clk);
        measure(800);
        check_count(n_m, 100, 0);
        wr(OFS_CTRL, 8'h04);
        fields(60, 1'b0);
        measure(800);
        check_count(n_m, 100, 0);
        fields(60, 1'b1);
        measure(800);
        check_count(n_m, 103, 1);
        wr(OFS_CTRL, 8'h08);
        measure(800);
        check_count(n_m, 100, 0);
        // Closed loop on the internal reference
        wr(OFS_CTRL, 8'h00);
        fields(60, 1'b0);
        measure(800);
        check_count(n_m, 103, 1);
        loopback <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            ctrl = ctrl_t'({2'b10, i[1:0]});
            wr(OFS_SERIAL_CLOCK_DIVIDER, 8'(i));
            wr(OFS_CHANNEL_CLOCK_DIVIDER, 8'(i + 1));
            wr(OFS_CTRL, {4'h0, ctrl});
            repeat (100) @(posedge clk);
            measure(1280);
            check_count(n_b, 80 / (i + 1), 1);
            check_count(n_c, 40 / ((i + 1) * (i + 1)), 1);
        end
        tally_and_finish();
    end
endmodule : field_locked_audio_clock_gen_tb
